// [hdl/vss_code_decode.sv]
// Voltage code to millivolt target decoder
`timescale 1ns/1ps
`include "vss_defs.svh"
module vss_code_decode (
    // Code in
    input wire logic [`VSS_CODE_W-1:0] code,
    // Target out, millivolts
    output logic [`VSS_MV_W-1:0] millivolts
);
    // Code zero is output off; otherwise base plus one step per code above one
    always_comb begin
        if (code == `VSS_OFF_CODE) begin
            millivolts = '0;
        end else begin
            millivolts = `VSS_BASE_MV
                + `VSS_MV_W'(`VSS_STEP_MV * `VSS_MV_W'(code - 8'h01));
        end
    end
endmodule

// [hdl/vss_sequencer.sv]
// Start-up, soft-start ramp, target decode and diode-mode gate cut-off
`timescale 1ns/1ps
`include "vss_defs.svh"
module vss_sequencer #(
    parameter int TIED_DELAY_CYC = `VSS_TIED_DELAY_CYC,
    parameter int STEP_CYC = `VSS_STEP_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Supply and enable
    input wire logic por_ok,
    input wire logic regulator_enable_input,
    input wire logic enable_tied_high,
    // Processor command
    input wire logic set_target_voltage_cmd,
    input wire logic [`VSS_CODE_W-1:0] cmd_code,
    // Gate control
    input wire logic light_load_diode_mode,
    input wire logic low_side_request,
    input wire logic phase_node_at_zero,
    // Outputs
    output logic [`VSS_CODE_W-1:0] voltage_code,
    output logic [`VSS_MV_W-1:0] target_mv,
    output logic power_good_output,
    output logic alert_n,
    output logic low_side_gate_drive
);
    vss_pkg::vss_state_e state, next_state;
    logic [`VSS_CODE_W-1:0] target, next_target;
    logic [`VSS_CODE_W-1:0] next_voltage_code;
    logic [31:0] timer, next_timer;
    logic next_power_good, next_alert_n, next_gate, cut, next_cut;
    logic [`VSS_MV_W-1:0] decoded;
    logic run;

    assign run = por_ok && regulator_enable_input;

    vss_code_decode u_dec (
        .code(voltage_code),
        .millivolts(decoded)
    );

    // Sequencer next state
    always_comb begin
        next_state = state;
        next_target = target;
        next_voltage_code = voltage_code;
        next_timer = timer;
        next_power_good = power_good_output;
        next_alert_n = alert_n;
        if (set_target_voltage_cmd) begin
            next_target = cmd_code;
        end
        case (state)
            vss_pkg::VSS_OFF: begin
                next_voltage_code = '0;
                next_power_good = 1'b0;
                next_alert_n = 1'b1;
                next_timer = '0;
                if (run) begin
                    next_state = enable_tied_high ? vss_pkg::VSS_WAIT : vss_pkg::VSS_RAMP;
                end
            end
            vss_pkg::VSS_WAIT: begin
                // Tied enable gives no edge, so a fixed delay marks the start
                if (timer >= 32'(TIED_DELAY_CYC - 1)) begin
                    next_timer = '0;
                    next_state = vss_pkg::VSS_RAMP;
                end else begin
                    next_timer = timer + 32'h1;
                end
            end
            vss_pkg::VSS_RAMP: begin
                if (voltage_code == next_target) begin
                    next_state = vss_pkg::VSS_DONE;
                    next_power_good = 1'b1;
                    next_alert_n = 1'b0;
                end else if (timer >= 32'(STEP_CYC - 1)) begin
                    next_timer = '0;
                    if (voltage_code < next_target) begin
                        next_voltage_code = voltage_code + 8'h01;
                    end else begin
                        next_voltage_code = voltage_code - 8'h01;
                    end
                end else begin
                    next_timer = timer + 32'h1;
                end
            end
            vss_pkg::VSS_DONE: begin
                next_voltage_code = next_target;
            end
            default: begin
                next_state = vss_pkg::VSS_OFF;
            end
        endcase
        // Dropping run clears state, code, timer and power good and raises alert_n at once (target is kept), so power good falls on the first clock edge after run drops
        if (!run) begin
            next_state = vss_pkg::VSS_OFF;
            next_voltage_code = '0;
            next_timer = '0;
            next_power_good = 1'b0;
            next_alert_n = 1'b1;
        end
    end

    // Low-side gate; cut holds until the current low-side request ends
    always_comb begin
        next_cut = cut;
        if (!low_side_request) begin
            next_cut = 1'b0;
        end else if (light_load_diode_mode && phase_node_at_zero) begin
            next_cut = 1'b1;
        end
        next_gate = low_side_request && !next_cut;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= vss_pkg::VSS_OFF;
            target <= '0;
            voltage_code <= '0;
            timer <= '0;
            power_good_output <= 1'b0;
            alert_n <= 1'b1;
            target_mv <= '0;
        end else begin
            state <= next_state;
            target <= next_target;
            voltage_code <= next_voltage_code;
            timer <= next_timer;
            power_good_output <= next_power_good;
            alert_n <= next_alert_n;
            target_mv <= decoded;
        end
    end

    // Gate state registers apart so the cut path stays one flop from the pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cut <= 1'b0;
            low_side_gate_drive <= 1'b0;
        end else begin
            cut <= next_cut;
            low_side_gate_drive <= next_gate;
        end
    end

    // Check-only counter: cycles the DAC code has sat still inside the ramp
    logic [31:0] step_gap, next_step_gap;

    always_comb begin
        next_step_gap = step_gap + 32'h1;
        if (state != vss_pkg::VSS_RAMP || next_voltage_code != voltage_code) begin
            next_step_gap = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            step_gap <= '0;
        end else begin
            step_gap <= next_step_gap;
        end
    end

    sequence s_wait_exit;
        state == vss_pkg::VSS_WAIT && next_state == vss_pkg::VSS_RAMP;
    endsequence

    sequence s_ramp_step;
        run && state == vss_pkg::VSS_RAMP && next_voltage_code != voltage_code;
    endsequence

    sequence s_done_hold;
        run && state == vss_pkg::VSS_DONE;
    endsequence

    sequence s_ramp_end;
        state == vss_pkg::VSS_RAMP && next_state == vss_pkg::VSS_DONE;
    endsequence

    a_pg_at_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_ramp_end |=> power_good_output && !alert_n)
        else $error("power good or alert wrong at ramp end");
    a_no_start_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !run |=> state == vss_pkg::VSS_OFF && !power_good_output)
        else $error("sequence active without enable");
    a_step_size: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == vss_pkg::VSS_RAMP && $past(state) == vss_pkg::VSS_RAMP
        |-> (voltage_code - $past(voltage_code)) inside {8'h00, 8'h01, 8'hff})
        else $error("ramp step larger than one code");
    a_gate_cut: assert property (@(posedge ref_clk) disable iff (sys_rst)
        light_load_diode_mode && phase_node_at_zero |=> !low_side_gate_drive)
        else $error("low side gate on after zero crossing");
    a_off_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == vss_pkg::VSS_OFF && $past(state) == vss_pkg::VSS_OFF |-> voltage_code == '0)
        else $error("dac not zero before ramp");
    a_wait_exit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_wait_exit |-> timer == 32'(TIED_DELAY_CYC - 1))
        else $error("ramp started before the tied enable delay");
    a_step_rate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_ramp_step |-> step_gap == 32'(STEP_CYC - 1))
        else $error("ramp step out of its fixed rate");
    a_done_track: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_done_hold |=> voltage_code == $past(next_target))
        else $error("code not following target after start");
    a_code_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        voltage_code == `VSS_OFF_CODE |=> target_mv == '0)
        else $error("code zero not decoded as output off");
    a_code_base: assert property (@(posedge ref_clk) disable iff (sys_rst)
        voltage_code == 8'h01 |=> target_mv == `VSS_BASE_MV)
        else $error("code one not decoded as base voltage");
    a_off_no_pg: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == vss_pkg::VSS_OFF |-> !power_good_output && alert_n)
        else $error("power good or alert active while off");
endmodule

// [inc/vss_defs.svh]
// Constants for the soft-start sequencer
`ifndef VSS_DEFS_SVH
`define VSS_DEFS_SVH
`define VSS_CODE_W 8
`define VSS_MV_W 11
`define VSS_CLK_HZ 10000000
`define VSS_TIED_DELAY_US 2600
`define VSS_TIED_DELAY_CYC ((`VSS_TIED_DELAY_US * (`VSS_CLK_HZ / 1000000)))
`define VSS_STEP_CYC 16
`define VSS_OFF_CODE 8'h00
`define VSS_BASE_MV 11'h0fa
`define VSS_STEP_MV 11'h005
`endif

// [inc/vss_pkg.sv]
// Types for the soft-start sequencer
package vss_pkg;
    typedef enum logic [2:0] {
        VSS_OFF,
        VSS_WAIT,
        VSS_RAMP,
        VSS_DONE
    } vss_state_e;
    typedef logic [7:0] vss_code_t;
endpackage

// [tb/vss_cpu_model.sv]
// Processor model issuing target voltage commands
`timescale 1ns/1ps
module vss_cpu_model (
    // Clock
    input wire logic ref_clk,
    // Command out
    output logic cmd,
    output logic [7:0] code
);
    initial begin
        cmd = 1'b0;
        code = 8'h00;
    end
    // Code is inverted after the pulse so a stale value is never mistaken for a command
    task automatic issue(input logic [7:0] c);
        @(posedge ref_clk);
        #10;
        cmd = 1'b1;
        code = c;
        @(posedge ref_clk);
        #10;
        cmd = 1'b0;
        code = ~c;
    endtask
endmodule

// [tb/vss_sequencer_tb.sv]
// Self-checking bench for the soft-start sequencer
`timescale 1ns/1ps
`include "vss_defs.svh"
module vss_sequencer_tb;
    localparam int STEP = 4;
    localparam int TIED = 20;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic por = 1'b0;
    logic en = 1'b0;
    logic tied = 1'b0;
    logic dio = 1'b0;
    logic req = 1'b0;
    logic zero = 1'b0;
    logic cmd;
    logic [7:0] cc;
    logic [7:0] vc;
    logic [10:0] mv;
    logic pg;
    logic al_n;
    logic gate;
    logic [7:0] c;
    int failures = 0;
    int cmp_count = 0;
    int n;
    always #50 ref_clk = ~ref_clk;
    vss_cpu_model cpu_u (.ref_clk(ref_clk), .cmd(cmd), .code(cc));
    vss_sequencer #(.TIED_DELAY_CYC(TIED), .STEP_CYC(STEP)) dut_u (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .por_ok(por), .regulator_enable_input(en),
        .enable_tied_high(tied), .set_target_voltage_cmd(cmd), .cmd_code(cc),
        .light_load_diode_mode(dio), .low_side_request(req), .phase_node_at_zero(zero),
        .voltage_code(vc), .target_mv(mv), .power_good_output(pg), .alert_n(al_n),
        .low_side_gate_drive(gate));
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #10;
    endtask
    // Bounded so a ramp that never ends still fails
    task automatic wait_pg();
        n = 0;
        while (pg !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        failures++;
        stop_test();
    end
    initial begin
        tick(12);
        sys_rst = 1'b0;
        chk({8'h00, pg, al_n, gate}, 11'h002);
        por = 1'b1;
        cpu_u.issue(8'h03);
        tick(40);
        chk({3'h0, vc}, 11'h000);
        en = 1'b1;
        wait_pg();
        chk(11'(n >= 3 * STEP && n <= 3 * STEP + 4), 11'h001);
        tick(1);
        chk({3'h0, vc}, 11'h003);
        chk({10'h000, al_n}, 11'h000);
        chk(mv, `VSS_BASE_MV + 11'h002 * `VSS_STEP_MV);
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'hff;
            cpu_u.issue(c);
            tick(2);
            chk({3'h0, vc}, {3'h0, c});
            chk(mv, (c == 8'h00) ? 11'h000 : `VSS_BASE_MV + 11'(c - 1) * `VSS_STEP_MV);
        end
        en = 1'b0;
        tick(2);
        chk({2'h0, pg, vc}, 11'h000);
        por = 1'b0;
        tied = 1'b1;
        en = 1'b1;
        cpu_u.issue(8'h02);
        tick(2);
        por = 1'b1;
        wait_pg();
        chk(11'(n >= TIED + 2 * STEP && n <= TIED + 2 * STEP + 6), 11'h001);
        dio = 1'b1;
        req = 1'b1;
        tick(2);
        chk({10'h000, gate}, 11'h001);
        zero = 1'b1;
        tick(2);
        chk({10'h000, gate}, 11'h000);
        dio = 1'b0;
        req = 1'b0;
        tick(2);
        req = 1'b1;
        tick(2);
        chk({10'h000, gate}, 11'h001);
        // Redirect mid-ramp: the latest command wins and the code walks back down
        en = 1'b0;
        tied = 1'b0;
        cpu_u.issue(8'h05);
        en = 1'b1;
        tick(13);
        chk({3'h0, vc}, 11'h003);
        cpu_u.issue(8'h01);
        wait_pg();
        chk({3'h0, vc}, 11'h001);
        stop_test();
    end
endmodule
